/* anp_pkg.sv */
package anp_pkg;
	// ==========================================
	// register word indexes (byte address = 4 * index)
	localparam logic [7:0] ANP_IDX_EXPANSION = 8'h06;
	localparam logic [7:0] ANP_IDX_TRANSMIT = 8'h07;
	localparam logic [7:0] ANP_IDX_RECEIVE = 8'h08;
	localparam logic [7:0] ANP_IDX_CONFIG = 8'h10;
	// ==========================================
	// expansion field positions
	localparam int ANP_EXP_BASE_PAGE = 5;
	localparam int ANP_EXP_PD_FAULT = 4;
	localparam int ANP_EXP_LP_NP_ABLE = 3;
	localparam int ANP_EXP_NP_ABLE = 2;
	localparam int ANP_EXP_PAGE_RX = 1;
	localparam int ANP_EXP_LP_AN_ABLE = 0;
	// ==========================================
	// code word field positions (transmit and receive), config alternate-mode bit
	localparam int ANP_CW_MORE = 15;
	localparam int ANP_CW_ACK = 14;
	localparam int ANP_CW_MSG = 13;
	localparam int ANP_CW_COMPLY = 12;
	localparam int ANP_CW_TOGGLE = 11;
	localparam int ANP_CFG_ALT_NP = 1;
	// ==========================================
	// reset values and transmit write mask
	localparam logic [15:0] ANP_TX_RESET = 16'h2001;
	localparam logic [15:0] ANP_RX_RESET = 16'h0000;
	localparam logic [15:0] ANP_TX_WMASK = 16'hBFFF;
	localparam logic ANP_CFG_ALT_RESET = 1'b0;
	localparam logic [31:0] ANP_UNMAPPED = 32'h00000000;

	// events from the negotiation engine
	typedef struct packed {
		logic base_page;
		logic pd_fault;
		logic lp_np_able;
		logic lp_an_able;
		logic page_rx;
		logic page_is_next;
		logic [15:0] page_word;
		logic mr_page_rx;
		logic transmit_disable;
		logic page_sent;
	} anp_engine_s;
endpackage

/* anp_regs.sv */
// Contract
// - expansion bit 5 latches high on base-page variable, read only.
// - base-page indication driven only while alternate next-page mode enabled.
// - parallel detection fault bit 4 latches until software reads it.
// - bit 3 reports partner next-page ability, read only.
// - bit 2 always reads one.
// - page-received bit 1 sets when a new page arrives, on the same edge that a next page is loaded.
// - reading expansion clears page-received; outside alternate mode it otherwise stays latched.
// - in alternate mode, mr_page_rx false or transmit_disable true clears page-received.
// - bit 0 reports partner auto-negotiation ability, read only.
// - transmit bit 15 is sent as more-pages flag.
// - transmit bit 12 is sent as the comply flag.
// - outgoing toggle is inverse of previous sent toggle, resets zero.
// - receive bit 15 captures partner more-pages flag.
// - receive bit 14 captures partner acknowledge.
// - receive bit 13 captures partner message-page flag.
// - receive bit 12 captures partner comply flag.
// - receive bit 11 captures partner toggle.
// - config bit 1 enables alternate mode, writable, resets zero.
module anp_regs
	import anp_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// negotiation engine
	input anp_pkg::anp_engine_s eng,
	output logic [15:0] tx_word,
	output logic alt_next_page_mode
);
	import anp_pkg::*;

	logic [15:0] tx_reg;
	logic [15:0] rx_reg;
	logic toggle_reg;
	logic alt_reg;
	logic base_reg;
	logic pdf_reg;
	logic prx_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic [15:0] exp_view;
	logic rd_exp;
	logic [15:0] wmask;

	// ==========================================
	// bus slave: one wait cycle, answered on the second edge
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	assign avs_readdata = rdata_reg;

	function automatic logic [15:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[1]}}, {8{be[0]}}};
	endfunction

	assign wmask = lane_mask(avs_byteenable);

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			ack_reg <= 1'b0;
		else
			ack_reg <= (avs_read | avs_write) & ~ack_reg;
	end

	// read fires only on the completing edge so a stalled read clears nothing early
	assign rd_exp = avs_read & ack_reg & (avs_address == ANP_IDX_EXPANSION);

	always_comb
	begin
		exp_view = 16'h0000;
		exp_view[ANP_EXP_BASE_PAGE] = base_reg & alt_reg;
		exp_view[ANP_EXP_PD_FAULT] = pdf_reg;
		exp_view[ANP_EXP_LP_NP_ABLE] = eng.lp_np_able;
		exp_view[ANP_EXP_NP_ABLE] = 1'b1;
		exp_view[ANP_EXP_PAGE_RX] = prx_reg;
		exp_view[ANP_EXP_LP_AN_ABLE] = eng.lp_an_able;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			rdata_reg <= ANP_UNMAPPED;
		else if (avs_read & ~ack_reg)
		begin
			case (avs_address)
				ANP_IDX_EXPANSION: rdata_reg <= {16'h0000, exp_view};
				ANP_IDX_TRANSMIT: rdata_reg <= {16'h0000, tx_reg[15:12], toggle_reg, tx_reg[10:0]};
				ANP_IDX_RECEIVE: rdata_reg <= {16'h0000, rx_reg};
				ANP_IDX_CONFIG: rdata_reg <= {30'h0, alt_reg, 1'b0};
				default: rdata_reg <= ANP_UNMAPPED;
			endcase
		end
	end

	// ==========================================
	// configuration
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			alt_reg <= ANP_CFG_ALT_RESET;
		else if (avs_write & ack_reg & (avs_address == ANP_IDX_CONFIG) & avs_byteenable[0])
			alt_reg <= avs_writedata[ANP_CFG_ALT_NP];
	end
	assign alt_next_page_mode = alt_reg;

	// ==========================================
	// latching flags; a new event wins over the read clear
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			base_reg <= 1'b0;
		else if (eng.base_page)
			base_reg <= 1'b1;
		else if (rd_exp)
			base_reg <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			pdf_reg <= 1'b0;
		else if (eng.pd_fault)
			pdf_reg <= 1'b1;
		else if (rd_exp)
			pdf_reg <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			prx_reg <= 1'b0;
		else if (eng.page_rx)
			prx_reg <= 1'b1;
		else if (rd_exp)
			prx_reg <= 1'b0;
		else if (alt_reg & (~eng.mr_page_rx | eng.transmit_disable))
			prx_reg <= 1'b0;
	end

	// ==========================================
	// transmit code word
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			tx_reg <= ANP_TX_RESET;
		else if (avs_write & ack_reg & (avs_address == ANP_IDX_TRANSMIT))
			tx_reg <= (tx_reg & ~(wmask & ANP_TX_WMASK)) | (avs_writedata[15:0] & wmask & ANP_TX_WMASK);
	end

	// toggle is owned by hardware so software cannot break the alternation
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			toggle_reg <= 1'b0;
		else if (eng.page_sent)
			toggle_reg <= ~toggle_reg;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			tx_word <= ANP_TX_RESET;
		else
			tx_word <= {tx_reg[ANP_CW_MORE], 1'b0, tx_reg[ANP_CW_MSG], tx_reg[ANP_CW_COMPLY], toggle_reg, tx_reg[10:0]};
	end

	// ==========================================
	// receive code word, base pages are held elsewhere
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			rx_reg <= ANP_RX_RESET;
		else if (eng.page_rx & eng.page_is_next)
			rx_reg <= eng.page_word;
	end

	// ==========================================
	// checks
	page_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		eng.page_rx |=> prx_reg) else $error("page flag not set");
	read_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		rd_exp & ~eng.page_rx |=> ~prx_reg) else $error("page flag not cleared by read");
	alt_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		alt_reg & ~eng.page_rx & eng.transmit_disable |=> ~prx_reg) else $error("alt clear missed");
	fault_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		pdf_reg & ~rd_exp |=> pdf_reg) else $error("fault flag dropped");
	np_able_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		avs_read & ~ack_reg & avs_address == ANP_IDX_EXPANSION |=> rdata_reg[ANP_EXP_NP_ABLE])
		else $error("next page able not one");
	toggle_flip_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		eng.page_sent |=> toggle_reg != $past(toggle_reg)) else $error("toggle not inverted");
	rx_capture_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		eng.page_rx & eng.page_is_next |=> rx_reg == $past(eng.page_word)) else $error("page not captured");
	reserved_tx_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		tx_word[ANP_CW_ACK] == 1'b0) else $error("reserved bit set");
	base_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		~alt_reg |-> ~exp_view[ANP_EXP_BASE_PAGE]) else $error("base page shown without alt mode");
	wait_one_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(avs_read) |-> avs_waitrequest ##1 ~avs_waitrequest) else $error("bus timing wrong");

	// ==========================================
	// outgoing code word follows the transmit register and the hardware toggle one cycle later
	more_sent_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		tx_word[ANP_CW_MORE] == $past(tx_reg[ANP_CW_MORE]))
		else $error("more pages bit not sent");

	msg_sent_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		tx_word[ANP_CW_MSG] == $past(tx_reg[ANP_CW_MSG]))
		else $error("message page bit not sent");

	comply_sent_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		tx_word[ANP_CW_COMPLY] == $past(tx_reg[ANP_CW_COMPLY]))
		else $error("comply bit not sent");

	toggle_sent_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		tx_word[ANP_CW_TOGGLE] == $past(toggle_reg))
		else $error("toggle bit not sent");

	code_sent_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		tx_word[10:0] == $past(tx_reg[10:0]))
		else $error("code field not sent");

	toggle_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		~eng.page_sent |=> $stable(toggle_reg))
		else $error("toggle moved without a page");

	tx_reserved_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		tx_reg[ANP_CW_ACK] == 1'b0)
		else $error("reserved transmit bit stored");

	tx_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		~(avs_write & ack_reg & (avs_address == ANP_IDX_TRANSMIT)) |=> $stable(tx_reg))
		else $error("transmit changed without a write");

	tx_comply_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		avs_write & ack_reg & (avs_address == ANP_IDX_TRANSMIT) & avs_byteenable[1]
		|=> tx_reg[ANP_CW_COMPLY] == $past(avs_writedata[ANP_CW_COMPLY]))
		else $error("comply bit not written");

	tx_low_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		avs_write & ack_reg & (avs_address == ANP_IDX_TRANSMIT) & avs_byteenable[0]
		|=> tx_reg[7:0] == $past(avs_writedata[7:0]))
		else $error("low code byte not written");

	// ==========================================
	// receive capture
	rx_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		~(eng.page_rx & eng.page_is_next) |=> $stable(rx_reg))
		else $error("receive changed without a next page");

	rx_more_bit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		eng.page_rx & eng.page_is_next |=> rx_reg[ANP_CW_MORE] == $past(eng.page_word[ANP_CW_MORE]))
		else $error("partner more bit lost");

	rx_ack_bit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		eng.page_rx & eng.page_is_next |=> rx_reg[ANP_CW_ACK] == $past(eng.page_word[ANP_CW_ACK]))
		else $error("partner acknowledge lost");

	rx_toggle_bit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		eng.page_rx & eng.page_is_next |=> rx_reg[ANP_CW_TOGGLE] == $past(eng.page_word[ANP_CW_TOGGLE]))
		else $error("partner toggle lost");

	// ==========================================
	// latching flags
	base_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		eng.base_page |=> base_reg)
		else $error("base page flag not set");

	base_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		base_reg & ~rd_exp |=> base_reg)
		else $error("base page flag dropped");

	fault_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		eng.pd_fault |=> pdf_reg)
		else $error("fault flag not set");

	fault_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		rd_exp & ~eng.pd_fault |=> ~pdf_reg)
		else $error("fault flag not cleared by read");

	prx_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		prx_reg & ~rd_exp & ~(alt_reg & (~eng.mr_page_rx | eng.transmit_disable)) |=> prx_reg)
		else $error("page flag dropped");

	alt_mr_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		alt_reg & ~eng.page_rx & ~eng.mr_page_rx |=> ~prx_reg)
		else $error("page flag kept with page rx false");

	no_alt_keep_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		~alt_reg & prx_reg & ~rd_exp |=> prx_reg)
		else $error("page flag cleared outside alternate mode");

	// ==========================================
	// expansion view
	lp_np_view_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		exp_view[ANP_EXP_LP_NP_ABLE] == eng.lp_np_able)
		else $error("partner next page ability wrong");

	lp_an_view_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		exp_view[ANP_EXP_LP_AN_ABLE] == eng.lp_an_able)
		else $error("partner negotiation ability wrong");

	np_view_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		exp_view[ANP_EXP_NP_ABLE])
		else $error("local next page ability not one");

	base_view_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		alt_reg |-> exp_view[ANP_EXP_BASE_PAGE] == base_reg)
		else $error("base page flag hidden in alternate mode");

	fault_view_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		exp_view[ANP_EXP_PD_FAULT] == pdf_reg)
		else $error("fault view wrong");

	prx_view_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		exp_view[ANP_EXP_PAGE_RX] == prx_reg)
		else $error("page flag view wrong");

	exp_upper_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		exp_view[15:6] == 10'h000)
		else $error("reserved expansion bits set");

	// ==========================================
	// configuration
	alt_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		avs_write & ack_reg & (avs_address == ANP_IDX_CONFIG) & avs_byteenable[0]
		|=> alt_reg == $past(avs_writedata[ANP_CFG_ALT_NP]))
		else $error("alternate mode not written");

	alt_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		~(avs_write & ack_reg & (avs_address == ANP_IDX_CONFIG)) |=> $stable(alt_reg))
		else $error("alternate mode changed without a write");

	alt_out_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		alt_next_page_mode == alt_reg)
		else $error("alternate mode output wrong");

	// ==========================================
	// bus handshake and read data
	wait_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(avs_write) |-> avs_waitrequest ##1 ~avs_waitrequest)
		else $error("write timing wrong");

	idle_wait_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		~avs_read & ~avs_write |-> ~avs_waitrequest)
		else $error("wait raised while idle");

	ack_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		ack_reg |=> ~ack_reg)
		else $error("acknowledge longer than one cycle");

	rdata_upper_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		avs_readdata[31:16] == 16'h0000)
		else $error("upper read lanes not zero");

	rdata_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		~(avs_read & ~ack_reg) |=> $stable(avs_readdata))
		else $error("read data moved between reads");

	rx_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		avs_read & ~ack_reg & (avs_address == ANP_IDX_RECEIVE) |=> avs_readdata[15:0] == $past(rx_reg))
		else $error("receive read wrong");

	tx_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		avs_read & ~ack_reg & (avs_address == ANP_IDX_TRANSMIT)
		|=> avs_readdata[ANP_CW_TOGGLE] == $past(toggle_reg))
		else $error("toggle read wrong");

	unmapped_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		avs_read & ~ack_reg & (avs_address != ANP_IDX_EXPANSION) & (avs_address != ANP_IDX_TRANSMIT)
		& (avs_address != ANP_IDX_RECEIVE) & (avs_address != ANP_IDX_CONFIG) |=> avs_readdata == ANP_UNMAPPED)
		else $error("unmapped read not zero");
endmodule

/* tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import anp_pkg::*;
	// ==========================================
	// stimulus, model state
	logic core_clk = 0;
	logic sys_rst = 1;
	logic [7:0] avs_address = 0;
	logic avs_read = 0;
	logic avs_write = 0;
	logic [31:0] avs_writedata = 0;
	logic [3:0] avs_byteenable = 4'h3;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [15:0] tx_word;
	logic alt_next_page_mode;
	anp_engine_s eng = '0;
	anp_engine_s lv = '0;
	anp_engine_s p;
	int errors = 0;
	int n_tests = 0;
	bit base, fault, prx, tog, altm;
	logic [15:0] txm = ANP_TX_RESET;
	logic [15:0] rxm = ANP_RX_RESET;
	logic [15:0] v;
	logic [31:0] rd;
	anp_regs dut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .eng(eng), .tx_word(tx_word),
		.alt_next_page_mode(alt_next_page_mode));
	initial forever #50 core_clk = ~core_clk;
	// ==========================================
	// tasks
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task print_verdict;
		if (errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// entered just after a rising edge; waitrequest and read data are taken at the completing edge
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= wd;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20)
			errors++;
		rd = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		@(posedge core_clk);
	endtask
	task rdx;
		bus(0, ANP_IDX_EXPANSION, 0);
		chk("expansion", rd, {26'h0, altm & base, fault, lv.lp_np_able, 1'b1, prx, lv.lp_an_able});
		base = 0;
		fault = 0;
		prx = 0;
	endtask
	// two more edges so the registered code word already shows the event
	task pulse(input anp_engine_s x);
		eng <= lv | x;
		@(posedge core_clk);
		eng <= lv;
		repeat (2) @(posedge core_clk);
	endtask
	// ==========================================
	// sequence
	initial
	begin
		#500000;
		errors++;
		print_verdict;
	end
	initial
	begin
		void'($urandom(32'h4d1ef9aa));
		repeat (3) @(posedge core_clk);
		sys_rst <= 0;
		chk("tx_word", tx_word, ANP_TX_RESET);
		rdx();
		bus(0, ANP_IDX_TRANSMIT, 0);
		chk("transmit", rd, {16'h0, txm});
		bus(0, ANP_IDX_CONFIG, 0);
		chk("config", rd, 32'h0);
		bus(1, 8'h20, 32'hFFFF);
		bus(0, 8'h20, 0);
		chk("unmapped", rd, ANP_UNMAPPED);
		// alt mode off: base hidden, page flag not cleared by level, non-next page not captured
		p = '0;
		p.base_page = 1;
		p.page_rx = 1;
		p.page_word = 16'hFFFF;
		lv.lp_np_able = 1;
		pulse(p);
		base = 1;
		prx = 1;
		rdx();
		rdx();
		bus(0, ANP_IDX_RECEIVE, 0);
		chk("receive", rd, {16'h0, rxm});
		repeat (4)
		begin
			v = 16'($urandom);
			bus(1, ANP_IDX_TRANSMIT, {16'h0, v});
			txm = (v & 16'hB7FF) | (16'(tog) << 11);
			bus(0, ANP_IDX_TRANSMIT, 0);
			chk("transmit", rd, {16'h0, txm});
			chk("tx_word", tx_word, txm);
			p = '0;
			p.page_sent = 1;
			pulse(p);
			tog = ~tog;
			txm[11] = tog;
			chk("toggle", tx_word, txm);
		end
		lv.mr_page_rx = 1;
		lv.lp_an_able = 1;
		bus(1, ANP_IDX_CONFIG, 32'h2);
		altm = 1;
		bus(0, ANP_IDX_CONFIG, 0);
		chk("config", rd, 32'h2);
		chk("alt", alt_next_page_mode, 1'b1);
		p = '0;
		p.base_page = 1;
		p.pd_fault = 1;
		p.page_rx = 1;
		p.page_is_next = 1;
		p.page_word = 16'($urandom);
		pulse(p);
		{base, fault, prx} = 3'b111;
		rxm = p.page_word;
		bus(0, ANP_IDX_RECEIVE, 0);
		chk("receive", rd, {16'h0, rxm});
		rdx();
		rdx();
		// both level causes clear the page flag before any read
		for (int k = 0; k < 2; k++)
		begin
			p = '0;
			p.page_rx = 1;
			pulse(p);
			lv.mr_page_rx = (k != 0);
			lv.transmit_disable = (k != 0);
			pulse('0);
			rdx();
			lv.mr_page_rx = 1;
			lv.transmit_disable = 0;
		end
		print_verdict;
	end
endmodule
